// ==== design/chss_consts.svh ====
`ifndef CHSS_CONSTS_SVH
`define CHSS_CONSTS_SVH
// ----------------------------------------------------------------
// mode encodings
// ----------------------------------------------------------------
`define CHSS_MODE_MEM   2'h0
`define CHSS_MODE_IO    2'h1
`define CHSS_MODE_DISK  2'h2
// ----------------------------------------------------------------
// widths and lane layout
// ----------------------------------------------------------------
`define CHSS_WORD_W     16
`define CHSS_BYTE_W     8
`define CHSS_LO_LSB     0
`define CHSS_HI_LSB     8
`define CHSS_WORD_RST   16'h0000
// ----------------------------------------------------------------
// host strobe timing, in clock cycles
// ----------------------------------------------------------------
`define CHSS_STROBE_LOW_CYC  2
`define CHSS_STROBE_HIGH_CYC 1
`endif

// ==== design/chss_pkg.sv ====
package chss_pkg;
  // operating mode of the card port
  typedef enum logic [1:0]
  {
    CHSS_MEM  = 2'h0,
    CHSS_IO   = 2'h1,
    CHSS_DISK = 2'h2
  } chss_mode_t;
  // lane routing chosen from enables and low address bit
  typedef enum logic [1:0]
  {
    CHSS_LANE_NONE = 2'h0,
    CHSS_LANE_EVEN = 2'h1,
    CHSS_LANE_ODD  = 2'h2,
    CHSS_LANE_WORD = 2'h3
  } chss_lane_t;
  // host write sequencer states
  typedef enum logic [1:0]
  {
    CHSS_H_IDLE = 2'h0,
    CHSS_H_LOW  = 2'h1,
    CHSS_H_HIGH = 2'h2
  } chss_hstate_t;
endpackage

// ==== design/chss_if.sv ====
`timescale 1ns/1ns
interface chss_if;
  logic        card_enable_low_lane_n;
  logic        card_enable_high_lane_n;
  logic        command_block_select_n;
  logic        control_block_select_n;
  logic        drive_role_select_n;
  logic        io_write_strobe_n;
  logic        dma_acknowledge_n;
  logic        disk_mode_select_n;
  logic        low_address_bit;
  logic [15:0] host_data;
  logic        udma_active;
  modport host
  (
    output card_enable_low_lane_n, card_enable_high_lane_n, command_block_select_n,
    output control_block_select_n, drive_role_select_n, io_write_strobe_n,
    output dma_acknowledge_n, disk_mode_select_n, low_address_bit, host_data,
    input  udma_active
  );
  modport card
  (
    input  card_enable_low_lane_n, card_enable_high_lane_n, command_block_select_n,
    input  control_block_select_n, drive_role_select_n, io_write_strobe_n,
    input  dma_acknowledge_n, disk_mode_select_n, low_address_bit, host_data,
    output udma_active
  );
endinterface

// ==== design/chss_card.sv ====
`timescale 1ns/1ns
`include "chss_consts.svh"
module chss_card
(
  input  wire logic              clk,            // system clock
  input  wire logic              rstn,           // sync reset, active low
  chss_if.card                   port,           // host pins
  input  wire logic              io_card_mode,   // card configured for I/O
  input  wire logic              dma_enable,     // DMA operation active
  input  wire logic              udma_start,     // begin an Ultra DMA burst
  output logic [15:0]            wr_data,        // captured write word
  output logic                   wr_valid,       // one-cycle capture pulse
  output logic                   wr_word,        // capture was 16 bits wide
  output logic                   wr_hi_lane,     // byte capture addressed odd byte
  output logic                   wr_command_grp, // capture hit command group
  output logic                   wr_control_grp, // capture hit control group
  output logic                   wr_dma,         // capture was a DMA transfer
  output chss_pkg::chss_mode_t   mode,           // decoded operating mode
  output logic                   is_master,      // drive role in disk mode
  output logic                   burst_stop      // one-cycle burst stop pulse
);
  import chss_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NP = 9;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_sync;
  logic [15:0]   d1_q;
  logic [15:0]   d2_q;
  assign pin_raw = {port.card_enable_low_lane_n, port.card_enable_high_lane_n,
                    port.command_block_select_n, port.control_block_select_n,
                    port.drive_role_select_n, port.io_write_strobe_n,
                    port.dma_acknowledge_n, port.disk_mode_select_n,
                    port.low_address_bit};
  // two flops per control pin, reset to the negated level so that no
  // false strobe edge or select follows reset; only the second flop is read
  for (genvar gi = 0; gi < NP; gi++)
  begin : g_pin_sync
    logic s1_q;
    logic s2_q;
    always_ff @(posedge clk)
    begin
      if (!rstn)
      begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
      end
      else
      begin
        s1_q <= pin_raw[gi];
        s2_q <= s1_q;
      end
    end
    assign pin_sync[gi] = s2_q;
  end

  // data lanes take the same two flops, so the word lines up with its strobe
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      d1_q <= `CHSS_WORD_RST;
      d2_q <= `CHSS_WORD_RST;
    end
    else
    begin
      d1_q <= port.host_data;
      d2_q <= d1_q;
    end
  end

  // synchronised pin names
  wire ce_lo_n  = pin_sync[8];
  wire ce_hi_n  = pin_sync[7];
  wire cs0_n    = pin_sync[6];
  wire cs1_n    = pin_sync[5];
  wire role_n   = pin_sync[4];
  wire wr_n     = pin_sync[3];
  wire dma_acknowledge_n_n  = pin_sync[2];
  wire dsel_n   = pin_sync[1];
  wire a0       = pin_sync[0];

  // ----------------------------------------------------------------
  // mode and lane decode
  // ----------------------------------------------------------------
  function automatic chss_lane_t lane_of(input logic lo_n, input logic hi_n,
                                         input logic addr0);
    chss_lane_t l;
    l = CHSS_LANE_NONE;
    if (!lo_n && !hi_n)
      l = CHSS_LANE_WORD;
    else if (!hi_n)
      l = CHSS_LANE_ODD;
    else if (!lo_n)
      l = addr0 ? CHSS_LANE_ODD : CHSS_LANE_EVEN;
    return l;
  endfunction

  chss_mode_t mode_d;
  assign mode_d = !dsel_n ? CHSS_DISK : (io_card_mode ? CHSS_IO : CHSS_MEM);
  wire disk_m = (mode_d == CHSS_DISK);
  wire card_m = !disk_m;
  wire dma_ack = dma_enable && !dma_acknowledge_n_n && disk_m;
  chss_lane_t lane;
  assign lane = lane_of(ce_lo_n, ce_hi_n, a0);
  wire card_sel = card_m && (lane != CHSS_LANE_NONE);
  wire cmd_sel  = disk_m && !cs0_n && !dma_ack;
  wire ctl_sel  = disk_m && !cs1_n && !dma_ack;
  wire any_sel  = card_sel || cmd_sel || ctl_sel || dma_ack;

  // strobe usable: not memory mode, not inside a burst
  logic udma_q;
  logic wr_prev_q;
  wire  wr_rise = wr_n && !wr_prev_q;
  wire  strobe_ok = (mode_d != CHSS_MEM) && !udma_q;

  // byte steering for 8-bit hosts: even byte onto the low lane, odd byte onto the high lane
  logic [15:0] cap_word;
  assign cap_word = (lane == CHSS_LANE_ODD && card_m)
                    ? {d2_q[15:8] | d2_q[7:0], 8'h00}
                    : ((lane == CHSS_LANE_EVEN && card_m)
                       ? {8'h00, d2_q[7:0]} : d2_q);
  wire is_word = dma_ack || disk_m || (lane == CHSS_LANE_WORD);

  // ----------------------------------------------------------------
  // capture, burst and role registers
  // ----------------------------------------------------------------
  // one trailing strobe edge while something is selected is one write
  wire capture = wr_rise && strobe_ok && any_sel;

  // edge history, mode and drive role
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_prev_q <= 1'b1;
      mode      <= CHSS_MEM;
      is_master <= 1'b0;
      wr_valid  <= 1'b0;
    end
    else
    begin
      wr_prev_q <= wr_n;
      mode      <= mode_d;
      is_master <= disk_m && !role_n;
      wr_valid  <= capture;
    end
  end

  // captured word and its qualifiers, held until the next write
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_data        <= `CHSS_WORD_RST;
      wr_word        <= 1'b0;
      wr_hi_lane     <= 1'b0;
      wr_command_grp <= 1'b0;
      wr_control_grp <= 1'b0;
      wr_dma         <= 1'b0;
    end
    else if (capture)
    begin
      wr_data        <= cap_word;
      wr_word        <= is_word;
      wr_hi_lane     <= (lane == CHSS_LANE_ODD);
      wr_command_grp <= cmd_sel;
      wr_control_grp <= ctl_sel;
      wr_dma         <= dma_ack;
    end
  end

  // burst start needs the strobe negated; a stop request beats a start
  wire stop_seen = udma_q && !wr_n;
  wire burst_go  = udma_start && disk_m && dma_enable && wr_n;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      udma_q     <= 1'b0;
      burst_stop <= 1'b0;
    end
    else
    begin
      burst_stop <= stop_seen;
      if (stop_seen)
        udma_q <= 1'b0;
      else if (burst_go)
        udma_q <= 1'b1;
    end
  end

  assign port.udma_active = udma_q;
endmodule

// ==== design/chss_host.sv ====
`timescale 1ns/1ns
`include "chss_consts.svh"
module chss_host
(
  input  wire logic               clk,          // system clock
  input  wire logic               rstn,         // sync reset, active low
  chss_if.host                    port,         // card pins
  input  wire chss_pkg::chss_mode_t mode_sel,   // mode to present
  input  wire logic               master_sel,   // strap this drive as master
  input  wire logic               req,          // start a write
  input  wire logic [1:0]         kind,         // 0 byte,1 word,2 command,3 control
  input  wire logic               addr0,        // low address bit
  input  wire logic [15:0]        data,         // write data
  input  wire logic               dma,          // write under DMA acknowledge
  input  wire logic               stop_req,     // request burst stop
  output logic                    busy          // write in progress
);
  import chss_pkg::*;

  chss_hstate_t st_q;
  chss_hstate_t st_d;
  logic [1:0]   cnt_q;
  logic [1:0]   kind_q;
  logic         a0_q;
  logic         dma_q;
  logic [15:0]  data_q;
  logic         udma_s1_q;
  logic         udma_s2_q;

  // ----------------------------------------------------------------
  // write sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      CHSS_H_IDLE: if (req && !udma_s2_q) st_d = CHSS_H_LOW;
      CHSS_H_LOW:  if (cnt_q == 2'(`CHSS_STROBE_LOW_CYC - 1)) st_d = CHSS_H_HIGH;
      CHSS_H_HIGH: if (cnt_q == 2'(`CHSS_STROBE_HIGH_CYC - 1)) st_d = CHSS_H_IDLE;
      default:     st_d = CHSS_H_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_q      <= CHSS_H_IDLE;
      cnt_q     <= 2'h0;
      kind_q    <= 2'h0;
      a0_q      <= 1'b0;
      dma_q     <= 1'b0;
      data_q    <= `CHSS_WORD_RST;
      udma_s1_q <= 1'b0;
      udma_s2_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      cnt_q     <= (st_d != st_q) ? 2'h0 : cnt_q + 2'h1;
      udma_s1_q <= port.udma_active;
      udma_s2_q <= udma_s1_q;
      if (st_q == CHSS_H_IDLE && req)
      begin
        kind_q <= kind;
        a0_q   <= addr0;
        dma_q  <= dma && (mode_sel == CHSS_DISK);
        data_q <= data;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  wire active   = (st_q != CHSS_H_IDLE);
  wire disk     = (mode_sel == CHSS_DISK);
  wire card_acc = active && !disk;
  assign busy = active;
  assign port.disk_mode_select_n     = !disk;
  assign port.drive_role_select_n    = disk ? !master_sel : 1'b0;
  assign port.card_enable_low_lane_n = !(card_acc && kind_q != 2'h2);
  assign port.card_enable_high_lane_n = !(card_acc && kind_q == 2'h1);
  assign port.low_address_bit        = a0_q;
  assign port.command_block_select_n = !(active && disk && !dma_q && kind_q != 2'h3);
  assign port.control_block_select_n = !(active && disk && !dma_q && kind_q == 2'h3);
  assign port.dma_acknowledge_n      = !(active && dma_q);
  // strobe negated entering burst; reused as stop within burst
  assign port.io_write_strobe_n = udma_s2_q ? !stop_req
                                            : !(st_q == CHSS_H_LOW);
  assign port.host_data = data_q;
endmodule

// ==== dv/chss_monitor.sv ====
`timescale 1ns/1ns
module chss_monitor
(
  input wire logic                 clk,                    // system clock
  input wire logic                 rstn,                   // sync reset, active low
  input wire logic                 card_enable_low_lane_n, // low lane enable
  input wire logic                 card_enable_high_lane_n, // high lane enable
  input wire logic                 command_block_select_n, // command group select
  input wire logic                 control_block_select_n, // control group select
  input wire logic                 drive_role_select_n,    // role strap pin
  input wire logic                 io_write_strobe_n,      // write strobe or stop
  input wire logic                 dma_acknowledge_n,      // dma acknowledge
  input wire logic                 disk_mode_select_n,     // disk mode pin
  input wire logic                 udma_active,            // burst running
  input wire logic                 wr_valid,               // capture pulse
  input wire logic                 wr_word,                // capture was a word
  input wire logic                 wr_dma,                 // capture under dma
  input wire logic                 wr_command_grp,         // command group hit
  input wire logic                 wr_control_grp,         // control group hit
  input wire chss_pkg::chss_mode_t mode,                   // decoded mode
  input wire logic                 is_master,              // drive role
  input wire logic                 burst_stop              // stop pulse
);
  import chss_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // pin and capture checks
  // ----------------------------------------------------------------
  cs_under_dma_acknowledge_n_a:
    assert property (!dma_acknowledge_n |-> command_block_select_n && control_block_select_n)
    else $error("chip select active under dma acknowledge");
  strobe_before_burst_a:
    assert property ($rose(udma_active) |-> io_write_strobe_n)
    else $error("burst entered with strobe asserted");
  stop_ends_burst_a:
    assert property ($fell(io_write_strobe_n) && udma_active |-> ##[1:6] burst_stop)
    else $error("stop request did not end burst");
  mem_ignores_strobe_a:
    assert property (mode == CHSS_MEM |-> !wr_valid)
    else $error("capture in memory mode");
  dma_is_word_a:
    assert property (wr_valid && wr_dma |-> wr_word && !wr_command_grp && !wr_control_grp)
    else $error("dma capture not a plain word");
  role_master_a:
    assert property ((!drive_role_select_n && mode == CHSS_DISK) [*6] |-> is_master)
    else $error("grounded role pin did not give master");
  role_slave_a:
    assert property (drive_role_select_n [*6] |-> !is_master)
    else $error("open role pin gave master");
  strobe_capture_a:
    assert property ($rose(io_write_strobe_n) && !udma_active
                     && ((mode == CHSS_IO
                          && !(card_enable_low_lane_n && card_enable_high_lane_n))
                         || (mode == CHSS_DISK
                             && !(command_block_select_n && control_block_select_n)))
                     |-> ##[2:6] wr_valid)
    else $error("trailing strobe edge not captured");
  disk_mode_a:
    assert property ($fell(disk_mode_select_n) |-> ##[1:4] mode == CHSS_DISK)
    else $error("grounded mode pin did not give disk mode");
  // main scenarios reached
  cover property (wr_valid && wr_word);
  cover property (wr_valid && wr_command_grp);
  cover property (burst_stop);
endmodule

// ==== dv/card_host_select_strobe_decode_test.sv ====
`timescale 1ns/1ns
module card_host_select_strobe_decode_test;
  import chss_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic       clk, rstn, req, addr0, dma, stop_req, master_sel, got, busy;
  logic       io_card_mode, dma_enable, udma_start, wr_valid, wr_word, wr_hi_lane;
  logic       wr_command_grp, wr_control_grp, wr_dma, is_master, burst_stop;
  logic [1:0] kind;
  logic [15:0] data, wr_data;
  chss_mode_t mode_sel, mode;
  int         mismatches, n_tests;
  chss_if     bus();
  chss_host chss_host_inst (.clk(clk), .rstn(rstn), .port(bus), .mode_sel(mode_sel),
    .master_sel(master_sel), .req(req), .kind(kind), .addr0(addr0), .data(data),
    .dma(dma), .stop_req(stop_req), .busy(busy));
  chss_card chss_card_inst (.clk(clk), .rstn(rstn), .port(bus), .io_card_mode(io_card_mode),
    .dma_enable(dma_enable), .udma_start(udma_start), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_word(wr_word), .wr_hi_lane(wr_hi_lane), .wr_command_grp(wr_command_grp),
    .wr_control_grp(wr_control_grp), .wr_dma(wr_dma), .mode(mode), .is_master(is_master),
    .burst_stop(burst_stop));
  chss_monitor chss_monitor_inst (.clk(clk), .rstn(rstn),
    .card_enable_low_lane_n(bus.card_enable_low_lane_n),
    .card_enable_high_lane_n(bus.card_enable_high_lane_n),
    .command_block_select_n(bus.command_block_select_n),
    .control_block_select_n(bus.control_block_select_n),
    .drive_role_select_n(bus.drive_role_select_n), .io_write_strobe_n(bus.io_write_strobe_n),
    .dma_acknowledge_n(bus.dma_acknowledge_n), .disk_mode_select_n(bus.disk_mode_select_n),
    .udma_active(bus.udma_active), .wr_valid(wr_valid), .wr_word(wr_word), .wr_dma(wr_dma),
    .wr_command_grp(wr_command_grp), .wr_control_grp(wr_control_grp), .mode(mode),
    .is_master(is_master), .burst_stop(burst_stop));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one host write, then a bounded wait for the card's capture
  task automatic put(input logic [1:0] k, input logic a0, input logic [15:0] d,
                     input logic dm, input logic exp);
    kind = k;
    addr0 = a0;
    data = d;
    dma = dm;
    req = 1'b1;
    tick(1);
    check("busy", busy, 1'b1);
    req = 1'b0;
    got = 1'b0;
    for (int i = 0; i < 12 && !got; i++)
    begin
      tick(1);
      got = (wr_valid === 1'b1);
    end
    check("capture", got, exp);
    if (exp && !got)
      wrap_up();
  endtask
  task automatic set_mode(input chss_mode_t m, input logic io);
    mode_sel = m;
    io_card_mode = io;
    tick(6);
    check("mode", mode, m);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_mem();
    set_mode(CHSS_MEM, 1'b0);
    put(2'h1, 1'b0, 16'hbeef, 1'b0, 1'b0);
    check("role in card mode", is_master, 1'b0);
  endtask
  task automatic t_io();
    set_mode(CHSS_IO, 1'b1);
    put(2'h0, 1'b0, 16'h00a5, 1'b0, 1'b1);
    check("even byte", wr_data[7:0], 8'ha5);
    check("even lane", {wr_word, wr_hi_lane}, 2'h0);
    put(2'h0, 1'b1, 16'h005a, 1'b0, 1'b1);
    check("odd byte", wr_data[15:8], 8'h5a);
    check("odd lane", {wr_word, wr_hi_lane}, 2'h1);
    put(2'h1, 1'b1, 16'hbeef, 1'b0, 1'b1);
    check("word data", wr_data, 16'hbeef);
    check("word flag", wr_word, 1'b1);
  endtask
  task automatic t_disk();
    set_mode(CHSS_DISK, 1'b0);
    check("master", is_master, 1'b1);
    put(2'h2, 1'b0, 16'h1234, 1'b0, 1'b1);
    check("command group", {wr_command_grp, wr_control_grp, wr_dma}, 3'h4);
    check("command data", wr_data, 16'h1234);
    put(2'h3, 1'b0, 16'h0006, 1'b0, 1'b1);
    check("control group", {wr_command_grp, wr_control_grp, wr_dma}, 3'h2);
    put(2'h1, 1'b0, 16'h4321, 1'b1, 1'b0);
    check("dma ignored", wr_dma, 1'b0);
    dma_enable = 1'b1;
    put(2'h1, 1'b0, 16'h8765, 1'b1, 1'b1);
    check("dma word", {wr_dma, wr_word, wr_command_grp, wr_control_grp}, 4'hc);
    check("dma data", wr_data, 16'h8765);
    master_sel = 1'b0;
    tick(6);
    check("slave", is_master, 1'b0);
  endtask
  task automatic t_burst();
    udma_start = 1'b1;
    tick(1);
    udma_start = 1'b0;
    for (int i = 0; i < 10 && bus.udma_active !== 1'b1; i++)
      tick(1);
    check("burst on", bus.udma_active, 1'b1);
    if (bus.udma_active !== 1'b1)
      wrap_up();
    stop_req = 1'b1;
    got = 1'b0;
    for (int i = 0; i < 10 && !got; i++)
    begin
      tick(1);
      got = (burst_stop === 1'b1);
    end
    check("stop pulse", got, 1'b1);
    if (!got)
      wrap_up();
    tick(3);
    check("burst off", bus.udma_active, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    {req, addr0, dma, stop_req, io_card_mode, dma_enable, udma_start} = 7'h00;
    kind = 2'h0;
    data = 16'h0000;
    master_sel = 1'b1;
    mode_sel = CHSS_MEM;
    mismatches = 0;
    n_tests = 0;
    tick(6);
    rstn = 1'b1;
    tick(1);
    t_mem();
    t_io();
    t_disk();
    t_burst();
    wrap_up();
  end
endmodule
